// ==== shared/tvl_pkg.sv ====
// Purpose: constants for the transfer vector lookup block
// Assumes: 20 MHz ref_clk, APB register access
// Notes:   sources are listed in fixed priority order, highest first
package tvl_pkg;
  localparam int          NSRC      = 40;
  localparam int          NEN       = 6;
  localparam logic [15:0] VEC_BASE  = 16'h0400;
  localparam logic [7:0]  RAM_UPPER = 8'hFF;
  localparam int          DESC_WRDS = 3;
  // register map, byte addresses
  localparam logic [7:0]  OFS_EN_A  = 8'h00;
  localparam logic [7:0]  OFS_SWVEC = 8'h18;
  localparam logic [7:0]  OFS_STAT  = 8'h1C;
  localparam logic [7:0]  OFS_DADR  = 8'h20;
  localparam int          SW_FLAG_B = 7;
  localparam logic [7:0]  EN_RST    = 8'h00;
  // vector number of each source, ascending
  localparam logic [6:0] SRC_VEC [NSRC] = '{
    7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
    7'h1C, 7'h20, 7'h21, 7'h22, 7'h23, 7'h28, 7'h29, 7'h2C,
    7'h2D, 7'h30, 7'h31, 7'h32, 7'h33, 7'h38, 7'h39, 7'h3C,
    7'h3D, 7'h40, 7'h41, 7'h44, 7'h45, 7'h48, 7'h49, 7'h4A,
    // last slot is the reserved request line, kept low by its driver
    7'h4B, 7'h51, 7'h52, 7'h55, 7'h56, 7'h59, 7'h5A, 7'h5A};
  // flat enable index: register*8 + (7 - bit)
  localparam logic [5:0] SRC_EN [NSRC] = '{
    6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
    6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10,
    6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h1A,
    6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h22,
    6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29, 6'h29};
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_VEC  = 2'b01,
    ST_DESC = 2'b10,
    ST_RUN  = 2'b11
  } tvl_state_t;
endpackage : tvl_pkg

// ==== design/tvl_lookup.sv ====
// Purpose: activation vector lookup and descriptor fetch
// Assumes: single clock; memory answers with mem_ack, any latency
// Notes:   transfer execution lives downstream; xfer_end closes a run
//
// Notes on behaviour
// R01 - software vector address is 0400 plus seven-bit field shifted left
// R02 - hardware vector address is 0400 plus twice the source vector number
// R03 - external pins 0-7 use vectors 16-23, enabled by A bits 7-0
// R04 - conversion end uses vector 28, enabled by B bit 6
// R05 - timer unit matches map to vectors 32-35,40-41,44-45,48-51,56-57,60-61
// R06 - byte timer matches use 64,65,68,69; dma ends use 72-75
// R07 - serial rx/tx use 81/82, 85/86, 89/90
// R08 - software first, then ascending vector number
// R09 - read vector entry first, then descriptor from that start address
// R10 - software aligns descriptor start to four bytes
// R11 - vector entries are two bytes at consecutive even addresses
// R12 - vector entry gives low bits of an on-chip RAM address
// R13 - enable one routes to controller, zero routes to the processor
// R14 - mask level and priority settings do not affect routed requests
// R15 - software keeps descriptors inside FFF800 to FFFBFF
// R16 - descriptor address is all-ones upper byte above the entry
// R17 - winning vector latched at vector read start
module tvl_lookup (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  // interrupt sources
  input  wire logic [tvl_pkg::NSRC-1:0]  src_req,
  output logic [tvl_pkg::NSRC-1:0]       cpu_irq_r,
  // memory read port
  output logic                           mem_req_r,
  output logic [23:0]                    mem_addr_r,
  output logic                           mem_wide_r,
  input  wire logic                      mem_ack,
  input  wire logic [31:0]               mem_rdata,
  // descriptor out
  output logic [31:0]                    desc_word_r,
  output logic [1:0]                     desc_idx_r,
  output logic                           desc_vld_r,
  output logic                           run_r,
  output logic                           soft_sel_r,
  input  wire logic                      xfer_end
);
  // ----------------------------------------------------------------
  // routing
  // ----------------------------------------------------------------
  logic [7:0]             en_r [tvl_pkg::NEN];
  logic [47:0]            en_flat;
  logic [tvl_pkg::NSRC-1:0] en_map;
  logic [tvl_pkg::NSRC-1:0] pend;

  genvar gi;
  generate
    for (gi = 0; gi < tvl_pkg::NEN; gi++) begin : g_flat
      assign en_flat[gi*8 +: 8] = {en_r[gi][0], en_r[gi][1], en_r[gi][2],
                                   en_r[gi][3], en_r[gi][4], en_r[gi][5],
                                   en_r[gi][6], en_r[gi][7]};
    end
    for (gi = 0; gi < tvl_pkg::NSRC; gi++) begin : g_map
      assign en_map[gi] = en_flat[tvl_pkg::SRC_EN[gi]]; // [R03] [R04]
    end
  endgenerate

  // no mask or priority level input exists on purpose  [R14]
  assign pend = src_req & en_map; // [R13]

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_irq_r <= '0;
    end else begin
      cpu_irq_r <= src_req & ~en_map; // [R13]
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic       hw_any;
  logic [6:0] hw_vec;

  always_comb begin
    hw_any = 1'b0;
    hw_vec = 7'h00;
    // lowest index wins: table is in ascending vector order
    for (int i = tvl_pkg::NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        hw_any = 1'b1;
        hw_vec = tvl_pkg::SRC_VEC[i]; // [R05] [R06] [R07] [R08]
      end
    end
  end

  // ----------------------------------------------------------------
  // fetch sequencer
  // ----------------------------------------------------------------
  tvl_pkg::tvl_state_t st_r;
  logic [6:0]  vec_r;
  logic [6:0]  sw_vec_r;
  logic        sw_flag_r;
  logic [23:0] dadr_r;
  logic [1:0]  cnt_r;
  logic        start;
  logic [15:0] vaddr;

  assign start = (st_r == tvl_pkg::ST_IDLE) && (sw_flag_r || hw_any);
  // two-byte entries at even addresses  [R11]
  assign vaddr = tvl_pkg::VEC_BASE + {8'h00, vec_r, 1'b0}; // [R01] [R02]

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r        <= tvl_pkg::ST_IDLE;
      vec_r       <= 7'h00;
      soft_sel_r  <= 1'b0;
      dadr_r      <= 24'h000000;
      cnt_r       <= 2'b00;
      mem_req_r   <= 1'b0;
      mem_addr_r  <= 24'h000000;
      mem_wide_r  <= 1'b0;
      desc_word_r <= 32'h00000000;
      desc_idx_r  <= 2'b00;
      desc_vld_r  <= 1'b0;
      run_r       <= 1'b0;
    end else begin
      desc_vld_r <= 1'b0;
      case (st_r)
        tvl_pkg::ST_IDLE: begin
          if (start) begin
            // latched here so late requests cannot redirect  [R17]
            vec_r      <= sw_flag_r ? sw_vec_r : hw_vec; // [R08]
            soft_sel_r <= sw_flag_r; // [R08]
            st_r       <= tvl_pkg::ST_VEC;
          end
        end
        tvl_pkg::ST_VEC: begin
          mem_req_r  <= 1'b1;
          mem_wide_r <= 1'b0; // [R11]
          mem_addr_r <= {8'h00, vaddr}; // [R09]
          if (mem_req_r && mem_ack) begin
            // entry is the low 16 bits of an on-chip RAM address  [R12]
            dadr_r     <= {tvl_pkg::RAM_UPPER, mem_rdata[15:0]}; // [R16]
            mem_addr_r <= {tvl_pkg::RAM_UPPER, mem_rdata[15:0]}; // [R09]
            mem_wide_r <= 1'b1;
            cnt_r      <= 2'b00;
            st_r       <= tvl_pkg::ST_DESC;
          end
        end
        tvl_pkg::ST_DESC: begin
          if (mem_ack) begin
            desc_word_r <= mem_rdata;
            desc_idx_r  <= cnt_r;
            desc_vld_r  <= 1'b1;
            // longword steps rely on four-byte aligned start  [R10]
            mem_addr_r  <= mem_addr_r + 24'h000004;
            cnt_r       <= cnt_r + 2'b01;
            if (cnt_r == 2'(tvl_pkg::DESC_WRDS - 1)) begin
              mem_req_r <= 1'b0;
              run_r     <= 1'b1;
              st_r      <= tvl_pkg::ST_RUN;
            end
          end
        end
        tvl_pkg::ST_RUN: begin
          if (xfer_end) begin
            run_r <= 1'b0;
            st_r  <= tvl_pkg::ST_IDLE;
          end
        end
        default: st_r <= tvl_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  logic        setup;
  logic        wr_go;
  logic [2:0]  en_sel;
  logic        en_hit;
  logic        sw_clr;

  assign setup  = psel && !penable;
  assign wr_go  = psel && penable && pready && pwrite;
  assign en_sel = paddr[4:2];
  assign en_hit = (paddr[7:5] == 3'b000) && (en_sel < 3'd6)
                  && (paddr[1:0] == 2'b00);
  assign sw_clr = (st_r == tvl_pkg::ST_RUN) && xfer_end && soft_sel_r;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < tvl_pkg::NEN; i++) begin
        en_r[i] <= tvl_pkg::EN_RST;
      end
    end else if (wr_go && en_hit) begin
      en_r[en_sel] <= pwdata[7:0];
    end
  end

  // a write that sets the flag beats the end-of-run clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_flag_r <= 1'b0;
      sw_vec_r  <= 7'h00;
    end else if (wr_go && paddr == tvl_pkg::OFS_SWVEC) begin
      sw_vec_r  <= pwdata[6:0];
      sw_flag_r <= pwdata[tvl_pkg::SW_FLAG_B] || (sw_flag_r && !sw_clr);
    end else if (sw_clr) begin
      sw_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      if (setup) begin
        prdata <= 32'h00000000;
        if (en_hit) begin
          prdata <= {24'h000000, en_r[en_sel]};
        end else if (paddr == tvl_pkg::OFS_SWVEC) begin
          prdata <= {24'h000000, sw_flag_r, sw_vec_r};
        end else if (paddr == tvl_pkg::OFS_STAT) begin
          prdata <= {21'h000000, soft_sel_r, st_r, 1'b0, vec_r};
        end else if (paddr == tvl_pkg::OFS_DADR) begin
          prdata <= {8'h00, dadr_r};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_VEC_ADDR: assert property ( // [R01]
    st_r == tvl_pkg::ST_VEC && mem_req_r |->
      mem_addr_r == {8'h00, 16'h0400 + {8'h00, vec_r, 1'b0}})
    else $error("vector address wrong");
  AST_EXTERNAL_INT_0_VEC: assert property ( // [R03]
    start && !sw_flag_r && pend[0] |=> vec_r == 7'h10)
    else $error("pin 0 vector not 16");
  AST_SOFT_FIRST: assert property ( // [R08]
    start && sw_flag_r |=> soft_sel_r && vec_r == $past(sw_vec_r))
    else $error("software not served first");
  AST_CPU_ROUTE: assert property ( // [R13]
    1'b1 |=> cpu_irq_r == $past(src_req & ~en_map))
    else $error("processor routing wrong");
  AST_DESC_FOLLOWS: assert property ( // [R09]
    st_r == tvl_pkg::ST_VEC && mem_req_r && mem_ack |=>
      st_r == tvl_pkg::ST_DESC && mem_addr_r[15:0] == $past(mem_rdata[15:0]))
    else $error("descriptor start not from entry");
  AST_ENTRY_NARROW: assert property ( // [R11]
    st_r == tvl_pkg::ST_VEC && mem_req_r |-> !mem_wide_r && !mem_addr_r[0])
    else $error("vector entry not two bytes");
  AST_RAM_UPPER: assert property ( // [R16]
    st_r == tvl_pkg::ST_DESC |-> mem_addr_r[23:16] == 8'hFF)
    else $error("descriptor outside on-chip RAM");
  AST_VEC_HELD: assert property ( // [R17]
    st_r != tvl_pkg::ST_IDLE && $past(st_r) != tvl_pkg::ST_IDLE
      |-> $stable(vec_r))
    else $error("latched vector changed");
  AST_ADC_EN: assert property ( // [R04]
    en_r[1][6] && src_req[8] |-> en_map[8] ##1 !cpu_irq_r[8])
    else $error("conversion end not routed by B6");
endmodule : tvl_lookup

// ==== dv/tvl_mem_model.sv ====
// Purpose: on-chip memory stand-in for vector and descriptor reads
// Assumes: request held until acknowledged
// Notes:   lag sets the wait before each ack, 0 is prompt
module tvl_mem_model (
  // clock
  input  wire logic        ref_clk,
  // read port
  input  wire logic        mem_req,
  input  wire logic [23:0] mem_addr,
  input  wire logic        mem_wide,
  input  wire logic [1:0]  lag,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    cnt = 2'h0;
  end
  always @(posedge ref_clk) begin
    if (mem_req && !mem_ack && cnt >= lag) begin
      mem_ack <= 1'b1;
      cnt <= 2'h0;
      // entry aligned and inside the ram window
      mem_rdata <= mem_wide ? {8'hA5, mem_addr}
                            : {16'h5A5A, 6'h3E, 1'b0, mem_addr[7:1], 2'h0};
    end else begin
      mem_ack <= 1'b0;
      cnt <= mem_req ? cnt + 2'h1 : 2'h0;
      // stale data must not look valid
      if (mem_ack) begin
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule : tvl_mem_model

// ==== dv/tvl_lookup_bench.sv ====
// Purpose: self-checking bench for the vector lookup
// Assumes: apb answers after one access cycle
// Notes:   expectations come from local tables, not the package
module tvl_lookup_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic        mem_req_r, mem_wide_r, mem_ack, desc_vld_r, run_r;
  logic        soft_sel_r, xfer_end, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, desc_word_r, mem_rdata, rd;
  logic [39:0] src_req, cpu_irq_r, r;
  logic [23:0] mem_addr_r;
  logic [1:0]  desc_idx_r, lag;
  logic [6:0]  v;
  int          failures, checks_done, seed, w, i, n;
  int vec_t [39] = '{16, 17, 18, 19, 20, 21, 22, 23, 28, 32, 33, 34, 35,
    40, 41, 44, 45, 48, 49, 50, 51, 56, 57, 60, 61, 64, 65, 68, 69,
    72, 73, 74, 75, 81, 82, 85, 86, 89, 90};

  tvl_lookup tvl_lookup_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .src_req(src_req), .cpu_irq_r(cpu_irq_r), .mem_req_r(mem_req_r),
    .mem_addr_r(mem_addr_r), .mem_wide_r(mem_wide_r), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .desc_word_r(desc_word_r),
    .desc_idx_r(desc_idx_r), .desc_vld_r(desc_vld_r), .run_r(run_r),
    .soft_sel_r(soft_sel_r), .xfer_end(xfer_end));
  tvl_mem_model tvl_mem_model_i (.ref_clk(ref_clk), .mem_req(mem_req_r),
    .mem_addr(mem_addr_r), .mem_wide(mem_wide_r), .lag(lag),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  function automatic int en_ix(int s);
    return s < 8 ? s : (s < 23 ? s + 1 : s + 3);
  endfunction : en_ix
  task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  // 0 ready, 1 memory request, 2 descriptor valid, else run
  function automatic logic probe(int k);
    case (k)
      0: return pready;
      1: return mem_req_r;
      2: return desc_vld_r;
      default: return run_r;
    endcase
  endfunction : probe
  task automatic wait_hi(int k);
    int t;
    t = 0;
    while (probe(k) !== 1'b1) begin
      @(posedge ref_clk);
      t++;
      if (t > 64) begin
        failures++;
        close_out();
      end
    end
  endtask : wait_hi
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    wait_hi(0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup never re-drives psel in this step
    @(posedge ref_clk);
  endtask : apb
  // mask bit 47-k enables flat index k
  task automatic set_en(logic [47:0] m);
    for (int g = 0; g < 6; g++) begin
      apb(1'b1, 8'(g * 4), {24'h0, m[47-8*g -: 8]});
      apb(1'b0, 8'(g * 4), 32'h0);
      chk("enable", {32'h0, m[47-8*g -: 8]}, {8'h0, rd});
    end
  endtask : set_en
  // later requests are noise that must not disturb the fetch
  task automatic act(logic [6:0] vn);
    logic [23:0] b;
    b = {8'hFF, 6'h3E, 1'b0, vn, 2'h0};
    wait_hi(1);
    chk("vaddr", 24'h400 + 24'(vn) * 2, mem_addr_r);
    chk("wide", 0, mem_wide_r);
    src_req <= 40'({$random(seed), $random(seed)}) & 40'h7F_FFFF_FFFF;
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      wait_hi(2);
      chk("idx", k, desc_idx_r);
      chk("word", {8'hA5, b + 24'(4 * k)}, desc_word_r);
    end
    src_req <= 40'h0;
    wait_hi(3);
    xfer_end <= 1'b1;
    @(posedge ref_clk);
    xfer_end <= 1'b0;
    @(posedge ref_clk);
    chk("run", 0, run_r);
  endtask : act

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    seed = 1145;
    sys_rst = 1'b1;
    {psel, penable, pwrite, xfer_end} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    src_req = 40'h0;
    lag = 2'h0;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk("idle", 0, {mem_req_r, run_r, desc_vld_r});
    // reset values, then one unmapped place read and written
    for (i = 0; i < 10; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("slverr", 40'(i == 9), err);
      chk("rstval", 0, rd);
    end
    apb(1'b1, 8'h24, 32'hFF);
    chk("wr_slverr", 1, err);
    // disabled requests go to the processor only
    src_req <= 40'({$random(seed), $random(seed)}) & 40'h7F_FFFF_FFFF;
    repeat (3) @(posedge ref_clk);
    chk("cpu_irq", src_req, cpu_irq_r);
    chk("noact", 0, mem_req_r);
    src_req <= 40'h0;
    // every source but the reserved last one alone, with its own enable bit
    for (i = 0; i < 39; i++) begin
      set_en(48'h1 << (47 - en_ix(i)));
      lag <= 2'($random(seed));
      src_req <= 40'h1 << i;
      act(7'(vec_t[i]));
    end
    // simultaneous requests, lowest index wins
    set_en(48'hFFFF_FFFF_FFFF);
    for (n = 0; n < 12; n++) begin
      r = 40'({$random(seed), $random(seed)}) & 40'h7F_FFFF_FFFF;
      r[38] = 1'b1;
      w = 38;
      for (int j = 38; j >= 0; j--) begin
        if (r[j]) begin
          w = j;
        end
      end
      lag <= 2'($random(seed));
      src_req <= r;
      act(7'(vec_t[w]));
      chk("soft", 0, soft_sel_r);
    end
    // software start, hardware requests raised only during its fetch
    for (n = 0; n < 4; n++) begin
      v = n == 0 ? 7'h00 : (n == 1 ? 7'h7F : 7'($random(seed)));
      apb(1'b1, 8'h18, {24'h0, 1'b1, v});
      src_req <= 40'({$random(seed), $random(seed)}) & 40'h7F_FFFF_FFFF;
      act(v);
      chk("soft", 1, soft_sel_r);
      apb(1'b0, 8'h18, 32'h0);
      chk("swflag", {33'h0, v}, {8'h0, rd});
    end
    close_out();
  end
endmodule : tvl_lookup_bench
